// ### bench/ocia_checker.sv
// Port assertions for the overflow/cell interrupt and APS block.
module ocia_checker (
  input wire logic                          MCLK_I,
  input wire logic                          RST_N_I,
  input wire logic                          PSEL_I,
  input wire logic                          PENABLE_I,
  input wire logic                          PWRITE_I,
  input wire logic [ocia_pkg::ADDR_W-1:0]   PADDR_I,
  input wire logic [ocia_pkg::DATA_W-1:0]   PWDATA_I,
  input wire logic [ocia_pkg::DATA_W-1:0]   PRDATA_O,
  input wire logic                          PREADY_O,
  input wire logic                          PSLVERR_O,
  input wire ocia_pkg::ocia_ovfl_evt_s      OVFL_EVENT_I,
  input wire ocia_pkg::ocia_cell_evt_s      CELL_EVENT_I,
  input wire ocia_pkg::ocia_aps_s           RX_APS_I,
  input wire logic                          RX_APS_VALID_I,
  input wire ocia_pkg::ocia_aps_s           TX_APS_O,
  input wire logic                          STAT_INT_O
);
  timeunit 1ns;
  timeprecision 100ps;
  import ocia_pkg::*;

  logic [15:0] ovfl_sh;
  logic [15:0] cell_sh;
  logic [15:0] held_sh;
  logic        evt_sh;
  logic        wr;
  logic        cause;

  assign wr = PSEL_I && PENABLE_I && PWRITE_I;
  assign cause = (|16'(OVFL_EVENT_I)) || (|16'(CELL_EVENT_I)) || RX_APS_VALID_I || wr;

  // Mirrors of the masks and of the held received pair.
  always_ff @(posedge MCLK_I) begin
    if (!RST_N_I) begin
      ovfl_sh <= 16'h0000;
      cell_sh <= 16'h0000;
      held_sh <= 16'h0000;
      evt_sh <= 1'b0;
    end else begin
      if (wr && PADDR_I == ADDR_OVFL_EN) ovfl_sh <= PWDATA_I[15:0];
      if (wr && PADDR_I == ADDR_CELL_EN) cell_sh <= PWDATA_I[15:0];
      if (wr && PADDR_I == ADDR_EVENT_EN) evt_sh <= PWDATA_I[EVT_APS_BIT];
      if (RX_APS_VALID_I) held_sh <= RX_APS_I;
    end
  end

  default clocking cb @(posedge MCLK_I); endclocking
  default disable iff (!RST_N_I);

  property p_tx_write;
    wr && PADDR_I == ADDR_APS_TX |=> TX_APS_O == $past(PWDATA_I[15:0]);
  endproperty
  property p_tx_read;
    PSEL_I && PENABLE_I && !PWRITE_I && PADDR_I == ADDR_APS_TX
      |-> PRDATA_O == {16'h0000, $past(TX_APS_O)};
  endproperty
  property p_rx_read;
    PSEL_I && PENABLE_I && !PWRITE_I && PADDR_I == ADDR_APS_RX
      |-> PRDATA_O == {16'h0000, $past(held_sh)};
  endproperty
  property p_ovfl_int;
    (|(16'(OVFL_EVENT_I) & ovfl_sh)) && !(wr && PADDR_I == ADDR_OVFL_EN) |=> STAT_INT_O;
  endproperty
  property p_cell_int;
    (|(16'(CELL_EVENT_I) & cell_sh)) && !(wr && PADDR_I == ADDR_CELL_EN) |=> STAT_INT_O;
  endproperty
  property p_aps_int;
    RX_APS_VALID_I && 16'(RX_APS_I) != held_sh && evt_sh && !(wr && PADDR_I == ADDR_EVENT_EN)
      |=> STAT_INT_O;
  endproperty
  property p_masked;
    ovfl_sh == 16'h0000 && cell_sh == 16'h0000 && !evt_sh |-> !STAT_INT_O;
  endproperty
  property p_rise;
    $rose(STAT_INT_O) |-> $past(cause);
  endproperty

  a_tx_write: assert property (p_tx_write)
    else $error("transmit pair differs from the written word");
  a_tx_read: assert property (p_tx_read)
    else $error("transmit pair read back wrong");
  a_rx_read: assert property (p_rx_read)
    else $error("received pair read back wrong");
  a_ovfl_int: assert property (p_ovfl_int)
    else $error("enabled overflow event gave no interrupt");
  a_cell_int: assert property (p_cell_int)
    else $error("enabled cell event gave no interrupt");
  a_aps_int: assert property (p_aps_int)
    else $error("changed received pair gave no interrupt");
  a_masked: assert property (p_masked)
    else $error("interrupt raised with every mask clear");
  a_rise: assert property (p_rise)
    else $error("interrupt rose without an event or a write");

  c_ovfl_int: cover property ((|16'(OVFL_EVENT_I)) ##1 STAT_INT_O);
  c_aps_change: cover property (RX_APS_VALID_I ##1 STAT_INT_O);
  c_slverr: cover property (PSLVERR_O);
endmodule

bind ocia_top ocia_checker u_ocia_checker (.MCLK_I, .RST_N_I, .PSEL_I, .PENABLE_I, .PWRITE_I,
  .PADDR_I, .PWDATA_I, .PRDATA_O, .PREADY_O, .PSLVERR_O, .OVFL_EVENT_I, .CELL_EVENT_I,
  .RX_APS_I, .RX_APS_VALID_I, .TX_APS_O, .STAT_INT_O);

// ### bench/ocia_host.sv
// Register bus master model standing for the host microprocessor.
module ocia_host (
  input  wire logic                        clk_i,
  output logic                             psel_o,
  output logic                             penable_o,
  output logic                             pwrite_o,
  output logic [ocia_pkg::ADDR_W-1:0]      paddr_o,
  output logic [ocia_pkg::DATA_W-1:0]      pwdata_o,
  input  wire logic [ocia_pkg::DATA_W-1:0] prdata_i,
  input  wire logic                        pready_i,
  input  wire logic                        pslverr_i
);
  timeunit 1ns;
  timeprecision 100ps;
  import ocia_pkg::*;

  initial begin
    psel_o = 1'b0;
    penable_o = 1'b0;
    pwrite_o = 1'b0;
    paddr_o = 8'h00;
    pwdata_o = 32'h0000_0000;
  end

  // One transfer, entered just after a rising edge; an idle cycle follows the release.
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                      output logic [31:0] rd, output logic err);
    psel_o <= 1'b1;
    penable_o <= 1'b0;
    pwrite_o <= wr;
    paddr_o <= a;
    pwdata_o <= wd;
    @(posedge clk_i);
    penable_o <= 1'b1;
    do @(posedge clk_i); while (pready_i !== 1'b1);
    rd = prdata_i;
    err = pslverr_i;
    psel_o <= 1'b0;
    penable_o <= 1'b0;
    @(posedge clk_i);
  endtask
endmodule

// ### bench/testbench.sv
// Self-checking testbench of the overflow/cell interrupt and APS block.
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  import ocia_pkg::*;

  logic           clk;
  logic           rst_n;
  logic           psel;
  logic           penable;
  logic           pwrite;
  logic [7:0]     paddr;
  logic [31:0]    pwdata;
  logic [31:0]    prdata;
  logic           pready;
  logic           pslverr;
  ocia_ovfl_evt_s ovfl_ev;
  ocia_cell_evt_s cell_ev;
  ocia_aps_s      rx_aps;
  ocia_aps_s      tx_aps;
  logic           rx_valid;
  logic           stat_int;
  int             num_errors;
  int             checks;
  int             cycles;
  logic [7:0]     regs[9] = '{ADDR_OVFL_EN, ADDR_CELL_EN, ADDR_APS_TX, ADDR_APS_RX,
                              ADDR_OVFL_STAT, ADDR_CELL_STAT, ADDR_EVENT_EN,
                              ADDR_EVENT_STAT, ADDR_IRQ_CAUSE};
  logic [15:0]    rxv[4] = '{16'h1234, 16'h1234, 16'h1235, 16'h9935};
  logic           evx[4] = '{1'b1, 1'b0, 1'b1, 1'b1};
  logic [15:0]    bitv;

  ocia_top u_ocia_top (.MCLK_I(clk), .RST_N_I(rst_n), .PSEL_I(psel), .PENABLE_I(penable),
    .PWRITE_I(pwrite), .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata),
    .PREADY_O(pready), .PSLVERR_O(pslverr), .OVFL_EVENT_I(ovfl_ev), .CELL_EVENT_I(cell_ev),
    .RX_APS_I(rx_aps), .RX_APS_VALID_I(rx_valid), .TX_APS_O(tx_aps), .STAT_INT_O(stat_int));

  ocia_host u_ocia_host (.clk_i(clk), .psel_o(psel), .penable_o(penable), .pwrite_o(pwrite),
    .paddr_o(paddr), .pwdata_o(pwdata), .prdata_i(prdata), .pready_i(pready),
    .pslverr_i(pslverr));

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  task automatic end_sim;
    if (num_errors == 0 && checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      num_errors++;
      end_sim();
    end
  end

  task automatic chk_word(input string name, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic chk_bit(input string name, input logic exp, input logic got);
    chk_word(name, {31'h0, exp}, {31'h0, got});
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic        e;
    u_ocia_host.xfer(1'b1, a, d, r, e);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic xe, input string n);
    logic [31:0] r;
    logic        e;
    u_ocia_host.xfer(1'b0, a, 32'h0, r, e);
    chk_word(n, exp, r);
    chk_bit("slave error", xe, e);
  endtask

  task automatic pulse(input logic [15:0] ov, input logic [15:0] ce);
    ovfl_ev <= ov;
    cell_ev <= ce;
    @(posedge clk);
    ovfl_ev <= 16'h0000;
    cell_ev <= 16'h0000;
    @(posedge clk);
  endtask

  initial begin
    rst_n = 1'b0;
    ovfl_ev = 16'h0000;
    cell_ev = 16'h0000;
    rx_aps = 16'h0000;
    rx_valid = 1'b0;
    num_errors = 0;
    checks = 0;
    cycles = 0;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    foreach (regs[j]) rd(regs[j], 32'h0, 1'b0, "reset value");
    chk_bit("reset interrupt", 1'b0, stat_int);
    wr(ADDR_OVFL_EN, 32'habcd_5a5a);
    rd(ADDR_OVFL_EN, 32'h0000_5a5a, 1'b0, "overflow enable");
    wr(ADDR_CELL_EN, 32'h1234_a5a5);
    rd(ADDR_CELL_EN, 32'h0000_a5a5, 1'b0, "cell enable");
    wr(ADDR_APS_TX, 32'h0000_c31e);
    chk_word("tx first byte", 32'hc3, {24'h0, tx_aps.first});
    chk_word("tx second byte", 32'h1e, {24'h0, tx_aps.second});
    rd(ADDR_APS_TX, 32'h0000_c31e, 1'b0, "tx pair");
    for (int k = 0; k < 2; k++) begin
      for (int i = 0; i < 16; i++) begin
        bitv = 16'h0001 << i;
        wr(k ? ADDR_CELL_EN : ADDR_OVFL_EN, {16'h0, ~bitv});
        pulse(k ? 16'h0 : bitv, k ? bitv : 16'h0);
        chk_bit("masked interrupt", 1'b0, stat_int);
        rd(k ? ADDR_CELL_STAT : ADDR_OVFL_STAT, {16'h0, bitv}, 1'b0, "status");
        wr(k ? ADDR_CELL_EN : ADDR_OVFL_EN, {16'h0, bitv});
        chk_bit("enabled interrupt", 1'b1, stat_int);
        wr(k ? ADDR_CELL_STAT : ADDR_OVFL_STAT, {16'h0, bitv});
        chk_bit("cleared interrupt", 1'b0, stat_int);
      end
    end
    wr(ADDR_OVFL_EN, 32'h0000_0001);
    wr(ADDR_CELL_EN, 32'h0000_0001);
    pulse(16'h0001, 16'h0001);
    rd(ADDR_IRQ_CAUSE, 32'h0000_0003, 1'b0, "both causes");
    wr(ADDR_OVFL_STAT, 32'h0000_0001);
    chk_bit("second source interrupt", 1'b1, stat_int);
    rd(ADDR_IRQ_CAUSE, 32'h0000_0002, 1'b0, "cell cause");
    wr(ADDR_CELL_STAT, 32'h0000_0001);
    chk_bit("no source interrupt", 1'b0, stat_int);
    wr(ADDR_EVENT_EN, 32'h0000_1000);
    rd(ADDR_EVENT_EN, 32'h0000_1000, 1'b0, "event enable");
    for (int j = 0; j < 4; j++) begin
      rx_aps <= rxv[j];
      rx_valid <= 1'b1;
      @(posedge clk);
      rx_valid <= 1'b0;
      rx_aps <= ~rxv[j];
      @(posedge clk);
      rd(ADDR_APS_RX, {16'h0, rxv[j]}, 1'b0, "received pair");
      chk_bit("change interrupt", evx[j], stat_int);
      rd(ADDR_EVENT_STAT, {19'h0, evx[j], 12'h0}, 1'b0, "event status");
      rd(ADDR_IRQ_CAUSE, {29'h0, evx[j], 2'h0}, 1'b0, "event cause");
      wr(ADDR_EVENT_STAT, 32'h0000_1000);
    end
    wr(ADDR_APS_RX, 32'h0000_ffff);
    rd(ADDR_APS_RX, 32'h0000_9935, 1'b0, "read-only pair");
    rd(8'h04, 32'h0, 1'b1, "unmapped read");
    end_sim();
  end
endmodule

// ### design/ocia_aps_rx.sv
// Capture of the received APS byte pair with change detection.
module ocia_aps_rx (
  input  wire logic               clk_i,
  input  wire logic               rst_n_i,
  input  wire ocia_pkg::ocia_aps_s rx_i,
  input  wire logic               valid_i,
  output ocia_pkg::ocia_aps_s     held_o,
  output logic                    change_o
);
  import ocia_pkg::*;

  typedef struct packed {
    ocia_aps_s held;
  } ocia_aps_rx_state_s;

  ocia_aps_rx_state_s state_reg;
  ocia_aps_rx_state_s state_next;

  always_comb begin
    state_next = state_reg;
    if (valid_i) begin
      state_next.held = rx_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      state_reg.held <= RST_APS;
    end else begin
      state_reg <= state_next;
    end
  end

  assign held_o   = state_reg.held;
  assign change_o = valid_i & (rx_i != state_reg.held);

endmodule

// ### design/ocia_sticky.sv
// Sticky status bits with write-one-to-clear and a mask that gates them onto a pending flag.
module ocia_sticky #(
  parameter int unsigned W = 16
) (
  input  wire logic         clk_i,
  input  wire logic         rst_n_i,
  input  wire logic [W-1:0] set_i,
  input  wire logic [W-1:0] clr_i,
  input  wire logic [W-1:0] en_i,
  output logic      [W-1:0] status_o,
  output logic              pend_o
);

  typedef struct packed {
    logic [W-1:0] status;
  } ocia_sticky_state_s;

  ocia_sticky_state_s state_reg;
  ocia_sticky_state_s state_next;
  logic [W-1:0]       bit_next;

  // Each bit is set by its event regardless of the mask; a set in the clear cycle wins.
  for (genvar i = 0; i < W; i++) begin : g_bit
    assign bit_next[i] = set_i[i] | (state_reg.status[i] & ~clr_i[i]);
  end

  always_comb begin
    state_next        = state_reg;
    state_next.status = bit_next;
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign status_o = state_reg.status;
  assign pend_o   = |(state_reg.status & en_i);

endmodule

// ### design/ocia_top.sv
// APB register block: overflow and cell interrupt masks, APS byte registers and status interrupt.
//
// Operation
// [R1] The overflow enable register at 0x2F lets each set bit pass the matching overflow status bit to the interrupt.
// [R2] The cell enable register at 0x30 lets each set bit pass the matching cell status bit to the interrupt.
// [R3] Overflow enable bits 15 down to 7 cover line error counters 9 down to 1.
// [R4] Overflow enable bits 6 to 2 cover idle, unmatched, nonzero flow control, length and CRC counters.
// [R5] Overflow enable bit 1 covers the uncorrected and bit 0 the corrected header check counter.
// [R6] Cell enable bits 15 down to 12 cover the transmitted cell counters of ports 3 down to 0.
// [R7] Cell enable bits 11 down to 8 cover the received cell counters of ports 3 down to 0.
// [R8] Cell enable bits 7 down to 4 cover the header match events of ports 3 down to 0.
// [R9] Cell enable bits 3 down to 0 cover the cell sent events of ports 3 down to 0.
// [R10] The transmit APS register at 0x32 supplies the first byte from bits 15-8 and the second from 7-0.
// [R11] The receive APS register holds the last first byte in bits 15-8 and second byte in 7-0.
// [R12] A received byte pair that differs from the held one sets event status bit 12.
// [R13] Status bits are set by events whatever the masks hold.
// [R14] The status interrupt is the OR of every status bit that has its enable bit set.
// [R15] The receive APS register is read-only and writes to it do nothing.
module ocia_top (
  input  wire logic                     MCLK_I,
  input  wire logic                     RST_N_I,
  input  wire logic                     PSEL_I,
  input  wire logic                     PENABLE_I,
  input  wire logic                     PWRITE_I,
  input  wire logic [ocia_pkg::ADDR_W-1:0] PADDR_I,
  input  wire logic [ocia_pkg::DATA_W-1:0] PWDATA_I,
  output logic      [ocia_pkg::DATA_W-1:0] PRDATA_O,
  output logic                          PREADY_O,
  output logic                          PSLVERR_O,
  input  wire ocia_pkg::ocia_ovfl_evt_s OVFL_EVENT_I,
  input  wire ocia_pkg::ocia_cell_evt_s CELL_EVENT_I,
  input  wire ocia_pkg::ocia_aps_s      RX_APS_I,
  input  wire logic                     RX_APS_VALID_I,
  output ocia_pkg::ocia_aps_s           TX_APS_O,
  output logic                          STAT_INT_O
);
  import ocia_pkg::*;

  ocia_top_state_s   state_reg;
  ocia_top_state_s   state_next;

  // Bus phase qualifiers.
  logic              setup_phase;
  logic              access_phase;
  logic              wr_access;

  // Address decode.
  logic              hit_event_en;
  logic              hit_ovfl_en;
  logic              hit_cell_en;
  logic              hit_aps_tx;
  logic              hit_aps_rx;
  logic              hit_event_stat;
  logic              hit_ovfl_stat;
  logic              hit_cell_stat;
  logic              hit_irq_cause;
  logic              hit_any;

  // Status sources and results.
  logic [REG_W-1:0]  ovfl_set;
  logic [REG_W-1:0]  cell_set;
  logic [REG_W-1:0]  ovfl_clr;
  logic [REG_W-1:0]  cell_clr;
  logic              event_clr;
  logic [REG_W-1:0]  ovfl_status;
  logic [REG_W-1:0]  cell_status;
  logic              event_status;
  logic              ovfl_pend;
  logic              cell_pend;
  logic              event_pend;
  ocia_aps_s         aps_rx_held;
  logic              aps_change;
  logic [CAUSE_W-1:0] irq_cause;
  logic [REG_W-1:0]  event_stat_word;
  logic [REG_W-1:0]  event_en_word;
  logic [DATA_W-1:0] read_word;

  assign setup_phase  = PSEL_I & ~PENABLE_I;
  assign access_phase = PSEL_I & PENABLE_I;
  assign wr_access    = access_phase & PWRITE_I;

  assign hit_event_en   = (PADDR_I == ADDR_EVENT_EN);
  assign hit_ovfl_en    = (PADDR_I == ADDR_OVFL_EN);
  assign hit_cell_en    = (PADDR_I == ADDR_CELL_EN);
  assign hit_aps_tx     = (PADDR_I == ADDR_APS_TX);
  assign hit_aps_rx     = (PADDR_I == ADDR_APS_RX);
  assign hit_event_stat = (PADDR_I == ADDR_EVENT_STAT);
  assign hit_ovfl_stat  = (PADDR_I == ADDR_OVFL_STAT);
  assign hit_cell_stat  = (PADDR_I == ADDR_CELL_STAT);
  assign hit_irq_cause  = (PADDR_I == ADDR_IRQ_CAUSE);

  assign hit_any = hit_event_en | hit_ovfl_en | hit_cell_en | hit_aps_tx | hit_aps_rx
                 | hit_event_stat | hit_ovfl_stat | hit_cell_stat | hit_irq_cause;

  // Event inputs map straight onto the status layout.
  assign ovfl_set = REG_W'(OVFL_EVENT_I); // R13
  assign cell_set = REG_W'(CELL_EVENT_I); // R13

  // Writing a one to a status bit clears it.
  assign ovfl_clr  = (wr_access & hit_ovfl_stat) ? PWDATA_I[REG_W-1:0] : '0;
  assign cell_clr  = (wr_access & hit_cell_stat) ? PWDATA_I[REG_W-1:0] : '0;
  assign event_clr = wr_access & hit_event_stat & PWDATA_I[EVT_APS_BIT];

  ocia_sticky #(
    .W (REG_W)
  ) u_ovfl_stat (
    .clk_i    (MCLK_I),
    .rst_n_i  (RST_N_I),
    .set_i    (ovfl_set),
    .clr_i    (ovfl_clr),
    .en_i     (REG_W'(state_reg.ovfl_en)), // R1
    .status_o (ovfl_status),
    .pend_o   (ovfl_pend)
  );

  ocia_sticky #(
    .W (REG_W)
  ) u_cell_stat (
    .clk_i    (MCLK_I),
    .rst_n_i  (RST_N_I),
    .set_i    (cell_set),
    .clr_i    (cell_clr),
    .en_i     (REG_W'(state_reg.cell_en)), // R2
    .status_o (cell_status),
    .pend_o   (cell_pend)
  );

  ocia_aps_rx u_aps_rx (
    .clk_i    (MCLK_I),
    .rst_n_i  (RST_N_I),
    .rx_i     (RX_APS_I),
    .valid_i  (RX_APS_VALID_I),
    .held_o   (aps_rx_held), // R11
    .change_o (aps_change)
  );

  ocia_sticky #(
    .W (1)
  ) u_event_stat (
    .clk_i    (MCLK_I),
    .rst_n_i  (RST_N_I),
    .set_i    (aps_change), // R12
    .clr_i    (event_clr),
    .en_i     (state_reg.event_en),
    .status_o (event_status),
    .pend_o   (event_pend)
  );

  assign irq_cause = {event_pend, cell_pend, ovfl_pend};

  always_comb begin
    event_stat_word              = '0;
    event_stat_word[EVT_APS_BIT] = event_status;
    event_en_word                = '0;
    event_en_word[EVT_APS_BIT]   = state_reg.event_en;
  end

  // Read data selection, sampled in the setup cycle.
  always_comb begin
    read_word = '0;
    if (hit_event_en) begin
      read_word[REG_W-1:0] = event_en_word;
    end else if (hit_ovfl_en) begin
      read_word[REG_W-1:0] = REG_W'(state_reg.ovfl_en);
    end else if (hit_cell_en) begin
      read_word[REG_W-1:0] = REG_W'(state_reg.cell_en);
    end else if (hit_aps_tx) begin
      read_word[REG_W-1:0] = REG_W'(state_reg.aps_tx);
    end else if (hit_aps_rx) begin
      read_word[REG_W-1:0] = REG_W'(aps_rx_held); // R11
    end else if (hit_event_stat) begin
      read_word[REG_W-1:0] = event_stat_word;
    end else if (hit_ovfl_stat) begin
      read_word[REG_W-1:0] = ovfl_status;
    end else if (hit_cell_stat) begin
      read_word[REG_W-1:0] = cell_status;
    end else if (hit_irq_cause) begin
      read_word[CAUSE_W-1:0] = irq_cause;
    end
  end

  always_comb begin
    state_next = state_reg;
    if (setup_phase) begin
      state_next.rdata  = read_word;
      state_next.slverr = ~hit_any;
    end
    if (wr_access) begin
      if (hit_event_en) begin
        state_next.event_en = PWDATA_I[EVT_APS_BIT];
      end
      if (hit_ovfl_en) begin
        // Fields of the overflow enable follow the status layout.
        state_next.ovfl_en = ocia_ovfl_evt_s'(PWDATA_I[REG_W-1:0]); // R3 R4 R5
      end
      if (hit_cell_en) begin
        state_next.cell_en = ocia_cell_evt_s'(PWDATA_I[REG_W-1:0]); // R6 R7 R8 R9
      end
      if (hit_aps_tx) begin
        state_next.aps_tx = ocia_aps_s'(PWDATA_I[REG_W-1:0]); // R10
      end
      // Writes to the receive APS register are dropped without error.
      if (hit_aps_rx) begin
        state_next.aps_tx = state_reg.aps_tx; // R15
      end
    end
  end

  always_ff @(posedge MCLK_I) begin
    if (!RST_N_I) begin
      state_reg.ovfl_en  <= ocia_ovfl_evt_s'(RST_MASK);
      state_reg.cell_en  <= ocia_cell_evt_s'(RST_MASK);
      state_reg.event_en <= 1'b0;
      state_reg.aps_tx   <= ocia_aps_s'(RST_APS);
      state_reg.rdata    <= RST_RDATA;
      state_reg.slverr   <= 1'b0;
    end else begin
      state_reg <= state_next;
    end
  end

  // The bus answers in the first access cycle.
  assign PREADY_O   = access_phase;
  assign PRDATA_O   = state_reg.rdata;
  assign PSLVERR_O  = access_phase & state_reg.slverr;
  assign TX_APS_O   = state_reg.aps_tx; // R10
  assign STAT_INT_O = ovfl_pend | cell_pend | event_pend; // R14

endmodule

// ### pkg/ocia_pkg.sv
// Shared constants, register map and carrier types of the overflow/cell interrupt and APS block.
package ocia_pkg;

  localparam int unsigned DATA_W = 32;
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned REG_W  = 16;
  localparam int unsigned PORTS  = 4;
  localparam int unsigned LINE_COUNTERS = 9;

  // Register indices; the byte address is four times the index.
  localparam logic [ADDR_W-1:0] IDX_EVENT_EN    = 8'h2e;
  localparam logic [ADDR_W-1:0] IDX_OVFL_EN     = 8'h2f;
  localparam logic [ADDR_W-1:0] IDX_CELL_EN     = 8'h30;
  localparam logic [ADDR_W-1:0] IDX_APS_TX      = 8'h32;
  localparam logic [ADDR_W-1:0] IDX_APS_RX      = 8'h33;
  localparam logic [ADDR_W-1:0] IDX_EVENT_STAT  = 8'h39;
  localparam logic [ADDR_W-1:0] IDX_OVFL_STAT   = 8'h3a;
  localparam logic [ADDR_W-1:0] IDX_CELL_STAT   = 8'h3b;
  localparam logic [ADDR_W-1:0] IDX_IRQ_CAUSE   = 8'h3f;

  localparam logic [ADDR_W-1:0] ADDR_EVENT_EN   = {IDX_EVENT_EN[5:0], 2'b00};
  localparam logic [ADDR_W-1:0] ADDR_OVFL_EN    = {IDX_OVFL_EN[5:0], 2'b00};
  localparam logic [ADDR_W-1:0] ADDR_CELL_EN    = {IDX_CELL_EN[5:0], 2'b00};
  localparam logic [ADDR_W-1:0] ADDR_APS_TX     = {IDX_APS_TX[5:0], 2'b00};
  localparam logic [ADDR_W-1:0] ADDR_APS_RX     = {IDX_APS_RX[5:0], 2'b00};
  localparam logic [ADDR_W-1:0] ADDR_EVENT_STAT = {IDX_EVENT_STAT[5:0], 2'b00};
  localparam logic [ADDR_W-1:0] ADDR_OVFL_STAT  = {IDX_OVFL_STAT[5:0], 2'b00};
  localparam logic [ADDR_W-1:0] ADDR_CELL_STAT  = {IDX_CELL_STAT[5:0], 2'b00};
  localparam logic [ADDR_W-1:0] ADDR_IRQ_CAUSE  = {IDX_IRQ_CAUSE[5:0], 2'b00};

  // Field positions.
  localparam int unsigned EVT_APS_BIT      = 12;
  localparam int unsigned CAUSE_OVFL_BIT   = 0;
  localparam int unsigned CAUSE_CELL_BIT   = 1;
  localparam int unsigned CAUSE_EVENT_BIT  = 2;
  localparam int unsigned CAUSE_W          = 3;

  // Reset values.
  localparam logic [REG_W-1:0]  RST_MASK  = 16'h0000;
  localparam logic [REG_W-1:0]  RST_APS   = 16'h0000;
  localparam logic [DATA_W-1:0] RST_RDATA = 32'h0000_0000;

  // Pair of APS bytes, first byte in the upper half as in the register.
  typedef struct packed {
    logic [7:0] first;
    logic [7:0] second;
  } ocia_aps_s;

  // Counter overflow events in the bit order of the overflow status register.
  typedef struct packed {
    logic [LINE_COUNTERS-1:0] line_cnt;
    logic                     idle_cell;
    logic                     unmatched_cell;
    logic                     nonzero_flowctl;
    logic                     payload_length_err;
    logic                     payload_crc_err;
    logic                     uncorrected_hdrcheck;
    logic                     corrected_hdrcheck;
  } ocia_ovfl_evt_s;

  // Per-port cell events in the bit order of the cell status register.
  typedef struct packed {
    logic [PORTS-1:0] tx_cnt_ovfl;
    logic [PORTS-1:0] rx_cnt_ovfl;
    logic [PORTS-1:0] hdr_match;
    logic [PORTS-1:0] cell_sent;
  } ocia_cell_evt_s;

  // Software-visible state of the top module.
  typedef struct packed {
    ocia_ovfl_evt_s    ovfl_en;
    ocia_cell_evt_s    cell_en;
    logic              event_en;
    ocia_aps_s         aps_tx;
    logic [DATA_W-1:0] rdata;
    logic              slverr;
  } ocia_top_state_s;

endpackage
